// ===== verilog/lacr_defs.vh
`ifndef LACR_DEFS_VH
`define LACR_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define LACR_ADDR_CMD1      3'h0
`define LACR_ADDR_CMD2      3'h1
`define LACR_ADDR_RES_LO    3'h2
`define LACR_ADDR_RES_HI    3'h3
`define LACR_ADDR_LOWLIM_LO 3'h4
`define LACR_ADDR_LOWLIM_HI 3'h5
`define LACR_ADDR_UPLIM_LO  3'h6
`define LACR_ADDR_UPLIM_HI  3'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define LACR_RST_CMD        8'h00
`define LACR_RST_RESULT     16'h0000
`define LACR_RST_LOWLIM     8'h00
`define LACR_RST_UPLIM      8'hFF

// ----------------------------------------
// field positions
// ----------------------------------------
`define LACR_OP_HI          7
`define LACR_OP_LO          5
`define LACR_FLAG_BIT       2
`define LACR_PERS_HI        1
`define LACR_PERS_LO        0
`define LACR_RES_HI         3
`define LACR_RES_LO         2
`define LACR_RANGE_HI       1
`define LACR_RANGE_LO       0

// ----------------------------------------
// operation modes
// ----------------------------------------
`define LACR_OP_DOWN        3'h0
`define LACR_OP_ALS_ONCE    3'h1
`define LACR_OP_IR_ONCE     3'h2
`define LACR_OP_ALS_CONT    3'h5
`define LACR_OP_IR_CONT     3'h6

// ----------------------------------------
// resolution codes and cycle counts
// ----------------------------------------
`define LACR_RES_16         2'h0
`define LACR_RES_12         2'h1
`define LACR_RES_8          2'h2
`define LACR_RES_4          2'h3
`define LACR_CYC_16         17'h10000
`define LACR_CYC_12         17'h01000
`define LACR_CYC_8          17'h00100
`define LACR_CYC_4          17'h00010

// ----------------------------------------
// range full-scale values in lux
// ----------------------------------------
`define LACR_SPAN_1         17'd1000
`define LACR_SPAN_2         17'd4000
`define LACR_SPAN_3         17'd16000
`define LACR_SPAN_4         17'd64000

// ----------------------------------------
// persistence counts
// ----------------------------------------
`define LACR_PERS_1         5'h01
`define LACR_PERS_4         5'h04
`define LACR_PERS_8         5'h08
`define LACR_PERS_16        5'h10

// ----------------------------------------
// timing
// ----------------------------------------
`define LACR_CLK_SYS_HZ     20000000
`define LACR_OSC_HZ         725000

`endif

// ===== verilog/lacr_light_adc_regs.v
// Notes on behaviour
// - resolution 00/01/10/11: 65536/4096/256/16 cycles, 16/12/8/4 bits
// - integration lasts exactly the cycle count chosen by resolution
// - range 00..11 selects range one to four, 1000 to 64000 lux
// - result low byte at 02, high byte at 03, both read-only
// - result right-aligned from bit zero, width set by resolution
// - both result registers overwritten when every conversion completes
// - lower threshold at 04/05, resets to 00
// - upper threshold at 06/07, resets to FF
// - integration is 2^n oscillator periods, oscillator near 725kHz
// - flag after m consecutive out-of-window results, m 1/4/8/16
`timescale 1ns/1ps
`include "lacr_defs.vh"

module lacr_light_adc_regs (
  input wire clk_sys,
  input wire reset,
  input wire [2:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [7:0] regRdData,
  input wire [15:0] adcSample,
  output reg [1:0] rangeSelect,
  output reg [16:0] fullScaleSpanLux,
  output wire irMode,
  output wire integrating,
  output reg conversionDone,
  output wire intOut,
  output wire intOe
);

  // ----------------------------------------
  // oscillator tick divider
  // ----------------------------------------
  // nearest lower divide: the tick runs slightly fast rather than slow
  localparam integer OSC_DIV = `LACR_CLK_SYS_HZ / `LACR_OSC_HZ;
  localparam integer OSC_LAST_I = OSC_DIV - 1;
  localparam [4:0] OSC_LAST = OSC_LAST_I[4:0];

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_INTEG = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [4:0] oscDivQ;
  reg oscTickQ;
  reg [7:0] cmd1Q;
  reg [3:0] cmd2Q;
  reg [15:0] resultQ;
  reg [15:0] lowLimQ;
  reg [15:0] upLimQ;
  reg [2:0] stateQ;
  reg [16:0] cycCntQ;
  reg [4:0] persCntQ;
  reg flagQ;
  reg [16:0] cycTarget;
  reg [15:0] resMask;
  reg [4:0] persTarget;
  reg [7:0] rdMux;

  wire [2:0] opMode = cmd1Q[`LACR_OP_HI:`LACR_OP_LO];
  wire opActive = (opMode == `LACR_OP_ALS_ONCE) ||
                  (opMode == `LACR_OP_IR_ONCE) ||
                  (opMode == `LACR_OP_ALS_CONT) ||
                  (opMode == `LACR_OP_IR_CONT);
  wire opContinuous = (opMode == `LACR_OP_ALS_CONT) ||
                      (opMode == `LACR_OP_IR_CONT);
  wire [15:0] newResult = adcSample & resMask;
  wire outOfWindow = (newResult < lowLimQ) || (newResult > upLimQ);
  wire cmd1Read = regRdEn && (regAddr == `LACR_ADDR_CMD1);
  wire cmd1Write = regWrEn && (regAddr == `LACR_ADDR_CMD1);

  assign irMode = (opMode == `LACR_OP_IR_ONCE) ||
                  (opMode == `LACR_OP_IR_CONT);
  assign integrating = (stateQ == ST_INTEG);
  // open-drain active-low pin: pulls low while the flag stands
  assign intOut = 1'b0;
  assign intOe = flagQ;

  // ----------------------------------------
  // decoders
  // ----------------------------------------
  // resolution cycle decode
  function [16:0] cyclesFor;
    input [1:0] res;
    begin
      case (res)
        `LACR_RES_16: cyclesFor = `LACR_CYC_16;
        `LACR_RES_12: cyclesFor = `LACR_CYC_12;
        `LACR_RES_8: cyclesFor = `LACR_CYC_8;
        default: cyclesFor = `LACR_CYC_4;
      endcase
    end
  endfunction

  always @* begin
    cycTarget = cyclesFor(cmd2Q[`LACR_RES_HI:`LACR_RES_LO]);
    resMask = cycTarget[15:0] - 16'h0001;
    case (cmd1Q[`LACR_PERS_HI:`LACR_PERS_LO])
      2'h0: persTarget = `LACR_PERS_1;
      2'h1: persTarget = `LACR_PERS_4;
      2'h2: persTarget = `LACR_PERS_8;
      default: persTarget = `LACR_PERS_16;
    endcase
  end

  // ----------------------------------------
  // range output
  // ----------------------------------------
  // range decode
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rangeSelect <= 2'h0;
      fullScaleSpanLux <= `LACR_SPAN_1;
    end else begin
      rangeSelect <= cmd2Q[`LACR_RANGE_HI:`LACR_RANGE_LO];
      case (cmd2Q[`LACR_RANGE_HI:`LACR_RANGE_LO])
        2'h0: fullScaleSpanLux <= `LACR_SPAN_1;
        2'h1: fullScaleSpanLux <= `LACR_SPAN_2;
        2'h2: fullScaleSpanLux <= `LACR_SPAN_3;
        default: fullScaleSpanLux <= `LACR_SPAN_4;
      endcase
    end
  end

  // ----------------------------------------
  // oscillator
  // ----------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      oscDivQ <= 5'h00;
      oscTickQ <= 1'b0;
    end else begin
      oscTickQ <= (oscDivQ == OSC_LAST);
      if (oscDivQ == OSC_LAST) begin
        oscDivQ <= 5'h00;
      end else begin
        oscDivQ <= oscDivQ + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmd1Q <= `LACR_RST_CMD;
      cmd2Q <= 4'h0;
      lowLimQ <= {`LACR_RST_LOWLIM, `LACR_RST_LOWLIM};
      upLimQ <= {`LACR_RST_UPLIM, `LACR_RST_UPLIM};
    end else begin
      if (cmd1Write) begin
        // flag bit is status, never written
        cmd1Q <= {regWrData[7:3], 1'b0, regWrData[1:0]};
      end else if (stateQ == ST_DONE && !opContinuous) begin
        // single measurement returns to power-down
        cmd1Q[`LACR_OP_HI:`LACR_OP_LO] <= `LACR_OP_DOWN;
      end
      if (regWrEn) begin
        case (regAddr)
          `LACR_ADDR_CMD2: cmd2Q <= regWrData[3:0];
          `LACR_ADDR_LOWLIM_LO: lowLimQ[7:0] <= regWrData;
          `LACR_ADDR_LOWLIM_HI: lowLimQ[15:8] <= regWrData;
          `LACR_ADDR_UPLIM_LO: upLimQ[7:0] <= regWrData;
          `LACR_ADDR_UPLIM_HI: upLimQ[15:8] <= regWrData;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    case (regAddr)
      `LACR_ADDR_CMD1: rdMux = {cmd1Q[7:3], flagQ, cmd1Q[1:0]};
      `LACR_ADDR_CMD2: rdMux = {4'h0, cmd2Q};
      `LACR_ADDR_RES_LO: rdMux = resultQ[7:0];
      `LACR_ADDR_RES_HI: rdMux = resultQ[15:8];
      `LACR_ADDR_LOWLIM_LO: rdMux = lowLimQ[7:0];
      `LACR_ADDR_LOWLIM_HI: rdMux = lowLimQ[15:8];
      `LACR_ADDR_UPLIM_LO: rdMux = upLimQ[7:0];
      default: rdMux = upLimQ[15:8];
    endcase
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      regRdData <= rdMux;
    end
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stateQ <= ST_IDLE;
      cycCntQ <= 17'h00000;
      resultQ <= `LACR_RST_RESULT;
      conversionDone <= 1'b0;
    end else begin
      conversionDone <= 1'b0;
      case (stateQ)
        ST_IDLE: begin
          cycCntQ <= 17'h00000;
          if (opActive && oscTickQ) begin
            stateQ <= ST_INTEG;
          end
        end
        ST_INTEG: begin
          if (!opActive) begin
            stateQ <= ST_IDLE;
          end else if (oscTickQ) begin
            // window ends at the chosen count
            if (cycCntQ + 17'h00001 >= cycTarget) begin
              resultQ <= newResult;
              conversionDone <= 1'b1;
              stateQ <= ST_DONE;
            end
            cycCntQ <= cycCntQ + 17'h00001;
          end
        end
        ST_DONE: begin
          cycCntQ <= 17'h00000;
          stateQ <= ST_IDLE;
        end
        default: stateQ <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // persistence and flag
  // ----------------------------------------
  wire convEnd = (stateQ == ST_INTEG) && oscTickQ && opActive &&
                 (cycCntQ + 17'h00001 >= cycTarget);

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      persCntQ <= 5'h00;
      flagQ <= 1'b0;
    end else begin
      if (convEnd) begin
        if (!outOfWindow) begin
          persCntQ <= 5'h00;
        end else if (persCntQ < persTarget) begin
          persCntQ <= persCntQ + 5'h01;
        end
      end
      // set wins over a clearing read in the same cycle
      if (convEnd && outOfWindow &&
          (persCntQ + 5'h01 >= persTarget)) begin
        flagQ <= 1'b1;
      end else if (cmd1Read) begin
        flagQ <= 1'b0;
      end
    end
  end

endmodule

// ===== testbench/lacr_light_adc_regs_assertions.sv
`timescale 1ns/1ps
module lacr_checker (
  input wire clk_sys,
  input wire reset,
  input wire [2:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regRdData,
  input wire [1:0] rangeSelect,
  input wire [16:0] fullScaleSpanLux,
  input wire conversionDone,
  input wire intOut,
  input wire intOe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // register port
  // ----------------------------------------
  AST_CTL_TOP_ZERO:
    assert property (regRdEn && regAddr == 3'h1 |=> regRdData[7:4] == 4'h0)
      else $error("control top bits not zero");
  AST_RANGE_FOLLOW:
    assert property (regWrEn && regAddr == 3'h1 |=> ##1
      {6'h00, rangeSelect} == ($past(regWrData, 2) & 8'h03))
      else $error("range select not taken");
  AST_SPAN_MAP:
    assert property (rangeSelect == $past(rangeSelect) |->
      fullScaleSpanLux == (17'd1000 << {rangeSelect, 1'b0}))
      else $error("span wrong for range");
  AST_LIMIT_RW:
    assert property (regWrEn && regAddr[2] ##1 !regWrEn ##1 regRdEn &&
      !regWrEn && regAddr == $past(regAddr, 2) |=>
      regRdData == $past(regWrData, 3))
      else $error("limit byte not stored");

  // ----------------------------------------
  // conversion and interrupt
  // ----------------------------------------
  AST_DONE_PULSE:
    assert property (conversionDone |=> !conversionDone)
      else $error("done longer than one cycle");
  AST_INT_CAUSE:
    assert property ($rose(intOe) |-> conversionDone)
      else $error("interrupt without conversion end");
  // a conversion end in the read cycle sets the flag again: set wins
  AST_INT_CLEAR:
    assert property (regRdEn && regAddr == 3'h0 |=>
      !intOe || conversionDone)
      else $error("interrupt not cleared by read");
  AST_INT_PIN_LOW:
    assert property (intOut == 1'b0)
      else $error("open drain data not low");

  COV_DONE: cover property (conversionDone);
  COV_INT: cover property ($rose(intOe));
  COV_CLR: cover property (regRdEn && regAddr == 3'h0 && intOe);
endmodule

// ===== testbench/lacr_host_model.sv
`timescale 1ns/1ps
module lacr_host_model (
  input wire clk_sys,
  input wire [7:0] regRdData,
  output reg [2:0] regAddr,
  output reg [7:0] regWrData,
  output reg regWrEn,
  output reg regRdEn
);
  initial begin
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end

  // idle data line shows the inverse, never a stale match
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
      regWrData <= ~d;
    end
  endtask

  task rd(input [2:0] a, output [7:0] d);
    begin
      @(posedge clk_sys);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk_sys);
      regRdEn <= 1'b0;
      #1;
      d = regRdData;
    end
  endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam TICK = 27;
  reg clk_sys;
  reg reset;
  reg [15:0] adcSample;
  wire [2:0] regAddr;
  wire [7:0] regWrData, regRdData;
  wire regWrEn, regRdEn, irMode, integrating, conversionDone, intOut, intOe;
  wire [1:0] rangeSelect;
  wire [16:0] fullScaleSpanLux;
  integer miscompares, num_checks, cycles, n, cnt, k;
  reg [7:0] rdv;
  reg [19:0] rows [0:13];

  lacr_host_model lacr_host_model_inst (.clk_sys(clk_sys),
    .regRdData(regRdData), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn));
  lacr_light_adc_regs lacr_light_adc_regs_inst (.clk_sys(clk_sys),
    .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .adcSample(adcSample), .rangeSelect(rangeSelect),
    .fullScaleSpanLux(fullScaleSpanLux), .irMode(irMode),
    .integrating(integrating), .conversionDone(conversionDone),
    .intOut(intOut), .intOe(intOe));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // whole run is about 9000 cycles, ceiling leaves twice that
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end

  task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s exp %0h got %0h", nm, e, g);
      end
    end
  endtask

  task final_report;
    begin
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // ----------------------------------------
  // one once-mode conversion, then flag readback
  // ----------------------------------------
  task conv(input [1:0] rc, input [7:0] op, input [15:0] smp,
    input [7:0] lo, input [31:0] len);
    begin
      lacr_host_model_inst.wr(3'h1, {4'h0, rc, 2'h0});
      adcSample <= smp;
      lacr_host_model_inst.wr(3'h0, op);
      #1;
      chk("irMode", op[6], irMode);
      cnt = 0;
      for (n = 0; n < 8000 && conversionDone !== 1'b1; n = n + 1) begin
        @(posedge clk_sys);
        #1;
        if (integrating === 1'b1) cnt = cnt + 1;
      end
      chk("intLen", len, cnt);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("intOe", 1, intOe);
      lacr_host_model_inst.rd(3'h2, rdv);
      chk("resLo", lo, rdv);
      lacr_host_model_inst.rd(3'h3, rdv);
      chk("resHi", 0, rdv);
      lacr_host_model_inst.rd(3'h0, rdv);
      chk("ctl0", 8'h04, rdv);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("intOeClr", 0, intOe);
    end
  endtask

  // ----------------------------------------
  // waits on the conversion sequencer
  // ----------------------------------------
  task waitDone;
    begin
      for (n = 0; n < 8000 && conversionDone !== 1'b1; n = n + 1) begin
        @(posedge clk_sys);
        #1;
      end
      chk("done", 1, conversionDone);
    end
  endtask

  task waitInteg;
    begin
      for (n = 0; n < 100 && integrating !== 1'b1; n = n + 1) begin
        @(posedge clk_sys);
        #1;
      end
      chk("integ", 1, integrating);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    reset = 1'b1;
    adcSample = 16'h0000;
    // {addr, write, data, expected read}
    rows = '{20'h00000, 20'h20000, 20'h40000, 20'h60000, 20'h80000,
      20'hA0000, 20'hC00FF, 20'hE00FF, 20'h5AA00, 20'h75500, 20'h91212,
      20'hB3434, 20'hD0505, 20'hF0000};
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    for (k = 0; k < 14; k = k + 1) begin
      if (rows[k][16]) lacr_host_model_inst.wr(rows[k][19:17], rows[k][15:8]);
      lacr_host_model_inst.rd(rows[k][19:17], rdv);
      chk("row", rows[k][7:0], rdv);
    end
    // range decode, upper nibble written as 1010
    for (k = 0; k < 4; k = k + 1) begin
      lacr_host_model_inst.wr(3'h1, 8'hAC | k[1:0]);
      lacr_host_model_inst.rd(3'h1, rdv);
      chk("ctl1", 8'h0C | k, rdv);
      chk("range", k, rangeSelect);
      chk("span", 1000 << (2 * k), fullScaleSpanLux);
    end
    // once modes: light at 4 bits, infrared at 8 bits
    conv(2'h3, 8'h20, 16'hABCD, 8'h0D, 16 * TICK);
    conv(2'h2, 8'h40, 16'h1234, 8'h34, 256 * TICK);
    // continuous infrared at 4 bits refreshes after every conversion
    lacr_host_model_inst.wr(3'h1, 8'h0C);
    adcSample <= 16'h0003;
    lacr_host_model_inst.wr(3'h0, 8'hC0);
    #1;
    chk("irCont", 1, irMode);
    waitDone;
    lacr_host_model_inst.rd(3'h2, rdv);
    chk("resCont1", 8'h03, rdv);
    @(posedge clk_sys);
    adcSample <= 16'h0009;
    waitDone;
    lacr_host_model_inst.rd(3'h2, rdv);
    chk("resCont2", 8'h09, rdv);
    lacr_host_model_inst.rd(3'h0, rdv);
    chk("ctlCont", 8'hC4, rdv);
    // reserved code stops a running integration with no result
    waitInteg;
    lacr_host_model_inst.wr(3'h0, 8'hA0);
    adcSample <= 16'h000E;
    #1;
    chk("irOff", 0, irMode);
    lacr_host_model_inst.wr(3'h0, 8'h80);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("abort", 0, integrating);
    repeat (480) @(posedge clk_sys);
    lacr_host_model_inst.rd(3'h2, rdv);
    chk("resKeep", 8'h09, rdv);
    // reset in mid-run, during an integration, restores the defaults
    lacr_host_model_inst.wr(3'h0, 8'hA0);
    waitInteg;
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk("rstInteg", 0, integrating);
    chk("rstSpan", 17'd1000, fullScaleSpanLux);
    chk("rstInt", 0, intOe);
    lacr_host_model_inst.rd(3'h6, rdv);
    chk("rstUpLo", 8'hFF, rdv);
    lacr_host_model_inst.rd(3'h5, rdv);
    chk("rstLoHi", 8'h00, rdv);
    lacr_host_model_inst.rd(3'h2, rdv);
    chk("rstRes", 8'h00, rdv);
    lacr_host_model_inst.rd(3'h0, rdv);
    chk("rstCtl", 8'h00, rdv);
    final_report;
  end
endmodule

bind lacr_light_adc_regs lacr_checker lacr_checker_inst (.clk_sys(clk_sys),
  .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .rangeSelect(rangeSelect), .fullScaleSpanLux(fullScaleSpanLux),
  .conversionDone(conversionDone), .intOut(intOut), .intOe(intOe));
